// File: rtl/pps_map.svh
// register offsets, field positions, reset values and timing counts of the parallel port
`ifndef PPS_MAP_SVH
`define PPS_MAP_SVH
// Operation
// - wide pins are gpio or slave data byte
// - three control pins each individually directed
// - mode bit 4 makes control pins strobes
// - software sets control directions to input
// - software sets control pins digital first
// - analog-selected control pins read as zero
// - directions still drive pins when analog
// - control pins analog after power-on reset
// - input-full flag bit 7 marks unread byte
// - output-full flag bit 6 marks unread output
// - overflow bit 5 on second write; software clears
// - status bit 3 always reads zero
// - direction one input, zero output; 0 rd
// - low read strobe while selected reads port
// - low write strobe while selected writes latch
// - select active low; high ignores strobes
// - write end sets input-full and irq flag
// - input-full clears on processor read; mode off clears
// - external read clears output-full at once
// - read end sets irq flag
`define PPS_OFS_WIDE_DATA 8'h08
`define PPS_OFS_CTRL_DATA 8'h09
`define PPS_OFS_WIDE_DIR 8'h88
`define PPS_OFS_STAT_DIR 8'h89
`define PPS_OFS_ANALOG 8'h9f
`define PPS_OFS_IRQ 8'h0c
`define PPS_RST_WIDE_DIR 8'hff
`define PPS_RST_STAT_DIR 8'h07
`define PPS_RST_ANALOG 8'h00
`define PPS_BIT_IN_FULL 7
`define PPS_BIT_OUT_FULL 6
`define PPS_BIT_OVF 5
`define PPS_BIT_MODE 4
`define PPS_BIT_IRQ 7
`define PPS_BIT_FMT 7
`define PPS_DIR_MASK 8'h07
`define PPS_ANA_MASK 8'h0f
`define PPS_ANA_DIGITAL 4'h6
`define PPS_END_DELAY 2
`define PPS_HOST_HOLD 4
`endif

// File: rtl/pps_pkg.sv
// types shared by both ends of the parallel port
package pps_pkg;
    typedef enum logic [1:0] {PPS_OP_NONE, PPS_OP_WRITE, PPS_OP_READ} pps_op_t;
endpackage

// File: rtl/pps_if.sv
// link between the port device and the external processor
`timescale 1ns/10ps
`default_nettype none
interface pps_if;
    logic [7:0] wide_o;
    logic [7:0] wide_oe;
    logic [7:0] wide_host_o;
    logic wide_host_oe;
    logic [2:0] ctrl_o;
    logic [2:0] ctrl_oe;
    logic [2:0] ctrl_host_o;
    logic [2:0] ctrl_host_oe;
    logic [7:0] wide_i;
    logic [2:0] ctrl_i;
    // resolved pin levels; undriven pins pull high
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            wide_i[i] = wide_oe[i] ? wide_o[i] : (wide_host_oe ? wide_host_o[i] : 1'b1);
        end
        for (int j = 0; j < 3; j++) begin
            ctrl_i[j] = ctrl_oe[j] ? ctrl_o[j] : (ctrl_host_oe[j] ? ctrl_host_o[j] : 1'b1);
        end
    end
    modport device (output wide_o, wide_oe, ctrl_o, ctrl_oe, input wide_i, ctrl_i);
    modport host (output wide_host_o, wide_host_oe, ctrl_host_o, ctrl_host_oe, input wide_i, ctrl_i);
endinterface
`default_nettype wire

// File: rtl/pps_device.sv
// port device: gpio ports, slave-mode latches, status flags and register port
`timescale 1ns/10ps
`default_nettype none
`include "pps_map.svh"
module pps_device
    import pps_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // pins
    pps_if.device pin
);
    logic [7:0] wide_out_q;
    logic [7:0] wide_in_q;
    logic [7:0] wide_dir_q;
    logic [2:0] ctrl_out_q;
    logic [2:0] ctrl_dir_q;
    logic mode_q;
    logic in_full_q;
    logic out_full_q;
    logic ovf_q;
    logic irq_q;
    logic [4:0] ana_q;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [7:0] wide_s1_q;
    logic [7:0] wide_s2_q;
    logic wr_act_q;
    logic rd_act_q;
    logic [1:0] wend_q;
    logic [1:0] rend_q;
    logic [7:0] wide_o_q;
    logic [7:0] wide_oe_q;
    logic [2:0] ctrl_o_q;
    logic [2:0] ctrl_oe_q;
    logic [7:0] rdata_q;
    logic wr_sel;
    logic rd_sel;
    logic analog_ctrl;
    logic cpu_rd_wide;
    logic [7:0] stat_val;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 3'h7;
            sync2_q <= 3'h7;
        end else begin
            sync1_q <= pin.ctrl_i;
            sync2_q <= sync1_q;
        end
    end

    assign wr_sel = mode_q && !sync2_q[2] && !sync2_q[1];
    assign rd_sel = mode_q && !sync2_q[2] && !sync2_q[0];
    // pins read analog unless configuration selects digital for all three
    assign analog_ctrl = (ana_q[3:0] != `PPS_ANA_DIGITAL) && (ana_q[3:0] != 4'h7);
    assign cpu_rd_wide = reg_rd && reg_addr == `PPS_OFS_WIDE_DATA;
    assign stat_val = {in_full_q, out_full_q, ovf_q, mode_q, 1'b0, ctrl_dir_q};

    // data pins delayed like the strobes, so the latch sees the byte the strobe framed
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wide_s1_q <= 8'hff;
            wide_s2_q <= 8'hff;
        end else begin
            wide_s1_q <= pin.wide_i;
            wide_s2_q <= wide_s1_q;
        end
    end

    // input latch captures the byte while the write is active
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wide_in_q <= 8'h00;
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
        end else begin
            wr_act_q <= wr_sel;
            rd_act_q <= rd_sel;
            if (wr_sel) begin
                wide_in_q <= wide_s2_q;
            end
        end
    end

    // end of a transfer sets flags five cycles after the strobe rises at the pin (two sync stages, end detect, two-stage delay)
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wend_q <= 2'h0;
            rend_q <= 2'h0;
        end else begin
            wend_q <= {wend_q[0], wr_act_q && !wr_sel};
            rend_q <= {rend_q[0], rd_act_q && !rd_sel};
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            in_full_q <= 1'b0;
            out_full_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            if (!mode_q) begin
                in_full_q <= 1'b0;
            end else if (wend_q[1]) begin
                in_full_q <= 1'b1;
            end else if (cpu_rd_wide) begin
                in_full_q <= 1'b0;
            end
            // a processor write in the cycle a read starts wins
            if (!mode_q) begin
                out_full_q <= 1'b0;
            end else if (reg_wr && reg_addr == `PPS_OFS_WIDE_DATA) begin
                out_full_q <= 1'b1;
            end else if (rd_sel && !rd_act_q) begin
                out_full_q <= 1'b0;
            end
            if (wr_sel && !wr_act_q && in_full_q) begin
                ovf_q <= 1'b1;
            end else if (reg_wr && reg_addr == `PPS_OFS_STAT_DIR && !reg_wdata[`PPS_BIT_OVF]) begin
                ovf_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_q <= 1'b0;
        end else if (wend_q[1] || rend_q[1]) begin
            irq_q <= 1'b1;
        end else if (reg_wr && reg_addr == `PPS_OFS_IRQ && !reg_wdata[`PPS_BIT_IRQ]) begin
            irq_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wide_out_q <= 8'h00;
            wide_dir_q <= `PPS_RST_WIDE_DIR;
            ctrl_out_q <= 3'h0;
            ctrl_dir_q <= 3'h7;
            mode_q <= 1'b0;
            ana_q <= 5'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                `PPS_OFS_WIDE_DATA: wide_out_q <= reg_wdata;
                `PPS_OFS_CTRL_DATA: ctrl_out_q <= reg_wdata[2:0];
                `PPS_OFS_WIDE_DIR: wide_dir_q <= reg_wdata;
                `PPS_OFS_STAT_DIR: begin
                    mode_q <= reg_wdata[`PPS_BIT_MODE];
                    ctrl_dir_q <= reg_wdata[2:0];
                end
                `PPS_OFS_ANALOG: ana_q <= {reg_wdata[`PPS_BIT_FMT], reg_wdata[3:0]};
                default: ;
            endcase
        end
    end

    // pin drivers; wide port follows direction bits only in port mode
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_wide
            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    wide_o_q[gi] <= 1'b0;
                    wide_oe_q[gi] <= 1'b0;
                end else if (mode_q) begin
                    wide_o_q[gi] <= wide_out_q[gi];
                    wide_oe_q[gi] <= rd_sel;
                end else begin
                    wide_o_q[gi] <= wide_out_q[gi];
                    wide_oe_q[gi] <= !wide_dir_q[gi];
                end
            end
        end
        for (gi = 0; gi < 3; gi++) begin : g_ctrl
            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    ctrl_o_q[gi] <= 1'b0;
                    ctrl_oe_q[gi] <= 1'b0;
                end else begin
                    ctrl_o_q[gi] <= ctrl_out_q[gi];
                    ctrl_oe_q[gi] <= !ctrl_dir_q[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `PPS_OFS_WIDE_DATA: rdata_q <= mode_q ? wide_in_q : pin.wide_i;
                `PPS_OFS_CTRL_DATA: rdata_q <= analog_ctrl ? 8'h00 : {5'h00, pin.ctrl_i};
                `PPS_OFS_WIDE_DIR: rdata_q <= wide_dir_q;
                `PPS_OFS_STAT_DIR: rdata_q <= stat_val;
                `PPS_OFS_ANALOG: rdata_q <= {ana_q[4], 3'h0, ana_q[3:0]};
                `PPS_OFS_IRQ: rdata_q <= {irq_q, 7'h00};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = rdata_q;
    assign pin.wide_o = wide_o_q;
    assign pin.wide_oe = wide_oe_q;
    assign pin.ctrl_o = ctrl_o_q;
    assign pin.ctrl_oe = ctrl_oe_q;
endmodule // pps_device
`default_nettype wire

// File: rtl/pps_host.sv
// external processor end: runs one strobed byte read or write per command
`timescale 1ns/10ps
`default_nettype none
`include "pps_map.svh"
module pps_host
    import pps_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // command port
    input wire pps_op_t cmd_op,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_wdata,
    output logic cmd_busy,
    output logic [7:0] cmd_rdata,
    output logic cmd_done,
    // pins
    pps_if.host pin
);
    typedef enum logic [1:0] {PPS_H_IDLE, PPS_H_ACT, PPS_H_GAP} pps_hst_t;
    pps_hst_t state_q;
    pps_op_t op_q;
    logic [2:0] cnt_q;
    logic [7:0] rdata_q;
    logic [7:0] wdata_q;
    logic done_q;
    logic busy_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= PPS_H_IDLE;
            op_q <= PPS_OP_NONE;
            cnt_q <= 3'h0;
            rdata_q <= 8'h00;
            wdata_q <= 8'h00;
            done_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                PPS_H_IDLE: begin
                    if (cmd_valid && cmd_op != PPS_OP_NONE) begin
                        op_q <= cmd_op;
                        wdata_q <= cmd_wdata;
                        cnt_q <= 3'h0;
                        busy_q <= 1'b1;
                        state_q <= PPS_H_ACT;
                    end
                end
                PPS_H_ACT: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == 3'(`PPS_HOST_HOLD - 1)) begin
                        if (op_q == PPS_OP_READ) begin
                            rdata_q <= pin.wide_i;
                        end
                        cnt_q <= 3'h0;
                        state_q <= PPS_H_GAP;
                    end
                end
                PPS_H_GAP: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == 3'(`PPS_HOST_HOLD - 1)) begin
                        done_q <= 1'b1;
                        busy_q <= 1'b0;
                        state_q <= PPS_H_IDLE;
                    end
                end
                default: state_q <= PPS_H_IDLE;
            endcase
        end
    end

    assign cmd_busy = busy_q;
    assign cmd_rdata = rdata_q;
    assign cmd_done = done_q;
    // strobes low only in the active phase, select held low with them
    assign pin.ctrl_host_oe = 3'h7;
    assign pin.ctrl_host_o[2] = state_q != PPS_H_ACT;
    assign pin.ctrl_host_o[1] = !(state_q == PPS_H_ACT && op_q == PPS_OP_WRITE);
    assign pin.ctrl_host_o[0] = !(state_q == PPS_H_ACT && op_q == PPS_OP_READ);
    assign pin.wide_host_o = wdata_q;
    assign pin.wide_host_oe = state_q == PPS_H_ACT && op_q == PPS_OP_WRITE;
endmodule // pps_host
`default_nettype wire

// File: tb/pps_chk.sv
// pin-level checker placed beside the link between the two ends
`timescale 1ns/10ps
`default_nettype none
module pps_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // link signals
    input wire logic [7:0] wide_oe,
    input wire logic wide_host_oe,
    input wire logic [2:0] ctrl_host_o,
    input wire logic [2:0] ctrl_i
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    property p_no_clash; wide_host_oe |-> wide_oe == 8'h00; endproperty
    a_no_clash: assert property (p_no_clash) else $error("wide pins driven by both ends");
    property p_rd_sync; $fell(ctrl_i[0]) && !ctrl_i[2] |=> $stable(wide_oe); endproperty
    a_rd_sync: assert property (p_rd_sync) else $error("wide drive too early after read start");
    property p_rd_drive; $fell(ctrl_i[0]) && !ctrl_i[2] |-> ##4 wide_oe == 8'hff; endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("wide pins not driven during read");
    property p_rd_release; $rose(ctrl_i[0]) |-> ##4 wide_oe == 8'h00; endproperty
    a_rd_release: assert property (p_rd_release) else $error("wide pins not released after read");
    property p_wr_hold; $fell(ctrl_host_o[1]) |-> (!ctrl_host_o[1]) [*4] ##1 ctrl_host_o[1]; endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write strobe length wrong");
    property p_rd_hold; $fell(ctrl_host_o[0]) |-> (!ctrl_host_o[0]) [*4] ##1 ctrl_host_o[0]; endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read strobe length wrong");
    property p_sel; !ctrl_host_o[1] || !ctrl_host_o[0] |-> !ctrl_host_o[2]; endproperty
    a_sel: assert property (p_sel) else $error("strobe without select");
    property p_excl; ctrl_host_o[1:0] != 2'b00; endproperty
    a_excl: assert property (p_excl) else $error("read and write strobes both low");
endmodule // pps_chk
`default_nettype wire

// File: tb/tb_parallel_port_and_control_pins.sv
// self-checking bench for the port device and its external processor end
`timescale 1ns/10ps
`default_nettype none
module tb_parallel_port_and_control_pins
    import pps_pkg::*;
;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    pps_op_t cmd_op = PPS_OP_NONE;
    logic cmd_valid = 1'b0;
    logic cmd_busy;
    logic cmd_done;
    logic [7:0] cmd_wdata = 8'h00;
    logic [7:0] cmd_rdata;
    logic [7:0] v;
    logic [7:0] w;
    int bad_count = 0;
    int checks = 0;
    int seed = 10;
    pps_if pin ();
    pps_device i_pps_device (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin(pin.device));
    pps_host i_pps_host (.clk_sys(clk_sys), .nrst(nrst), .cmd_op(cmd_op), .cmd_valid(cmd_valid),
        .cmd_wdata(cmd_wdata), .cmd_busy(cmd_busy), .cmd_rdata(cmd_rdata), .cmd_done(cmd_done), .pin(pin.host));
    pps_chk i_pps_chk (.clk_sys(clk_sys), .nrst(nrst), .wide_oe(pin.wide_oe), .wide_host_oe(pin.wide_host_oe),
        .ctrl_host_o(pin.ctrl_host_o), .ctrl_i(pin.ctrl_i));
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // expected status byte; bit 3 always zero
    function automatic logic [7:0] stat_exp(input logic in_full, input logic out_full, input logic ovf,
        input logic mode, input logic [2:0] dir);
        return {in_full, out_full, ovf, mode, 1'b0, dir};
    endfunction
    task automatic rw(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        cmp8(name, exp, reg_rdata);
    endtask
    // one strobed transfer, then room for the flags to settle
    task automatic host(input pps_op_t op, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        cmd_op <= op;
        cmd_wdata <= d;
        cmd_valid <= 1'b1;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        #1;
        cmp8("host_busy", 8'h01, {7'h00, cmd_busy});
        while (cmd_done !== 1'b1) begin
            @(posedge clk_sys);
            #1;
            n++;
            if (n > 40) begin
                bad_count++;
                wrap_up();
            end
        end
        cmp8("host_idle", 8'h00, {7'h00, cmd_busy});
        repeat (3) @(posedge clk_sys);
    endtask
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(8'h88, 8'hff, "wide_dir");
        rd(8'h89, stat_exp(1'b0, 1'b0, 1'b0, 1'b0, 3'h7), "status");
        rd(8'h9f, 8'h00, "analog_cfg");
        rd(8'h09, 8'h00, "ctrl_data");
        rd(8'h55, 8'h00, "unmapped");
        rw(8'h89, 8'h2f);
        rd(8'h89, stat_exp(1'b0, 1'b0, 1'b0, 1'b0, 3'h7), "status");
        v = 8'($random(seed));
        rw(8'h88, 8'h00);
        rw(8'h08, v);
        rd(8'h08, v, "wide_pins");
        rw(8'h88, 8'hff);
        rw(8'h9f, 8'h06);
        rw(8'h89, 8'h03);
        rw(8'h09, 8'h00);
        rd(8'h09, 8'h03, "ctrl_pins");
        rw(8'h9f, 8'h00);
        rd(8'h09, 8'h00, "ctrl_analog");
        rw(8'h89, 8'h07);
        rw(8'h9f, 8'h06);
        host(PPS_OP_WRITE, 8'h3c);
        rd(8'h89, stat_exp(1'b0, 1'b0, 1'b0, 1'b0, 3'h7), "mode_off_write");
        rw(8'h89, 8'h17);
        for (int i = 0; i < 4; i++) begin
            w = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            host(PPS_OP_WRITE, w);
            rd(8'h89, stat_exp(1'b1, 1'b0, 1'b0, 1'b1, 3'h7), "status_in_full");
            rd(8'h0c, 8'h80, "irq_write");
            rw(8'h0c, 8'h00);
            rd(8'h08, w, "in_latch");
            rd(8'h89, stat_exp(1'b0, 1'b0, 1'b0, 1'b1, 3'h7), "status_read");
        end
        host(PPS_OP_WRITE, 8'h5a);
        host(PPS_OP_WRITE, 8'ha5);
        rd(8'h89, stat_exp(1'b1, 1'b0, 1'b1, 1'b1, 3'h7), "status_ovf");
        rd(8'h08, 8'ha5, "in_latch");
        rd(8'h89, stat_exp(1'b0, 1'b0, 1'b1, 1'b1, 3'h7), "status_ovf");
        rw(8'h89, 8'h17);
        rw(8'h0c, 8'h00);
        rd(8'h89, stat_exp(1'b0, 1'b0, 1'b0, 1'b1, 3'h7), "status_clr");
        v = 8'($random(seed));
        rw(8'h08, v);
        rd(8'h89, stat_exp(1'b0, 1'b1, 1'b0, 1'b1, 3'h7), "status_out_full");
        host(PPS_OP_READ, 8'h00);
        cmp8("host_rdata", v, cmd_rdata);
        rd(8'h89, stat_exp(1'b0, 1'b0, 1'b0, 1'b1, 3'h7), "status_out_full");
        rd(8'h0c, 8'h80, "irq_read");
        rw(8'h08, v);
        rw(8'h89, 8'h07);
        rd(8'h89, stat_exp(1'b0, 1'b0, 1'b0, 1'b0, 3'h7), "mode_off");
        wrap_up();
    end
endmodule // tb_parallel_port_and_control_pins
`default_nettype wire
